// File: lels_cfg.svh
// constants for the little-endian lane steering block
`ifndef LELS_CFG_SVH
`define LELS_CFG_SVH
`define LELS_SIZE_BYTE 2'h0
`define LELS_SIZE_WORD 2'h1
`define LELS_SIZE_LONG 2'h2
`define LELS_SIZE_QUAD 2'h3
`define LELS_DW_8 2'h0
`define LELS_DW_16 2'h1
`define LELS_DW_32 2'h2
`define LELS_LANES 4
`define LELS_BEAT_W 69
`define LELS_BUF_DEPTH 2
`endif

// File: lels_pkg.sv
// types for the little-endian lane steering block
package lels_pkg;
  typedef enum logic [1:0] {
    LELS_IDLE,
    LELS_ISSUE,
    LELS_DRAIN
  } lels_state_t;
  typedef struct packed {
    logic write;
    logic [3:0] strobe;
    logic [31:0] addr;
    logic [31:0] data;
  } lels_beat_t;
endpackage

// File: lels_beat_if.sv
// one external bus cycle passed from the sequencer to the buffer
`timescale 1ns/1ps
interface lels_beat_if;
  import lels_pkg::*;
  logic valid;
  logic ready;
  lels_beat_t beat;
  modport src (output valid, output beat, input ready);
  modport snk (input valid, input beat, output ready);
endinterface

// File: lels_pair_buf.sv
// two-entry buffer holding bus cycles ahead of the external bus
`timescale 1ns/1ps
`include "lels_cfg.svh"
module lels_pair_buf import lels_pkg::*; #(
  parameter int WIDTH = `LELS_BEAT_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  lels_beat_if.snk in_side,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [`LELS_BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // full and empty come straight from the count, so a stalled bus fills it
  assign in_side.ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_side.valid && in_side.ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= WIDTH'(in_side.beat);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: lels_lane_steer.sv
// little-endian byte-lane steering of processor accesses onto an external bus
// Notes on behaviour
// [RULE1] 32-bit device: byte k on lane k; narrow accesses use only their own lanes.
// [RULE2] quad to 32-bit device: two cycles, 8n then 8n+4, all four strobes.
// [RULE3] 16-bit device: lanes 0-1 only; long two cycles, quad four, low half first.
// [RULE4] 8-bit device: lane 0 only; word 2, long 4, quad 8 cycles, ascending.
// [RULE5] strobe k serves as write enable, column strobe and SDRAM mask of lane k.
// [RULE6] unused lanes carry don't-care data and keep their strobes negated.
`timescale 1ns/1ps
`include "lels_cfg.svh"
module lels_lane_steer import lels_pkg::*; (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [1:0] dev_width,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_addr,
  input wire logic [63:0] req_wdata,
  output logic rsp_valid,
  output logic [63:0] rsp_rdata,
  output logic bus_valid,
  input wire logic bus_ready,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  output logic write_lane0_strobe,
  output logic write_lane1_strobe,
  output logic write_lane2_strobe,
  output logic write_lane3_strobe,
  output logic column_lane0_strobe,
  output logic column_lane1_strobe,
  output logic column_lane2_strobe,
  output logic column_lane3_strobe,
  output logic sdram_lane0_mask,
  output logic sdram_lane1_mask,
  output logic sdram_lane2_mask,
  output logic sdram_lane3_mask
);
  lels_state_t state;
  logic acc_write;
  logic [31:0] acc_addr;
  logic [63:0] acc_wdata;
  logic [1:0] wlog;
  logic [1:0] blog;
  logic [3:0] beats;
  logic [1:0] lane;
  logic [3:0] issued;
  logic [3:0] acked;
  logic [63:0] rdata;
  logic [1:0] next_wlog;
  logic [1:0] next_blog;
  logic [1:0] next_cnt_log;
  logic [3:0] beat_mask;
  logic [5:0] src_shift;
  logic [5:0] dst_shift;
  logic [63:0] beat_src;
  logic [31:0] rd_lanes;
  logic [63:0] rd_piece;
  lels_beat_t out_beat;
  logic [`LELS_BEAT_W-1:0] out_raw;
  logic bus_take;
  logic req_take;
  logic issue_take;
  logic last_take;

  lels_beat_if beat_ch ();

  // device width in log2 bytes; an unknown code falls back to 32 bits
  always_comb begin
    unique case (dev_width)
      `LELS_DW_8: next_wlog = 2'h0;
      `LELS_DW_16: next_wlog = 2'h1;
      default: next_wlog = 2'h2;
    endcase
    next_blog = (req_size < next_wlog) ? req_size : next_wlog;
    next_cnt_log = (req_size > next_wlog) ? (req_size - next_wlog) : 2'h0;
  end

  assign req_ready = (state == LELS_IDLE);
  assign req_take = req_valid && req_ready;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= LELS_IDLE;
    end else begin
      unique case (state)
        LELS_IDLE: begin
          if (req_valid) begin
            state <= LELS_ISSUE;
          end
        end
        LELS_ISSUE: begin
          if (issue_take && issued == beats - 4'h1) begin
            state <= LELS_DRAIN;
          end
        end
        LELS_DRAIN: begin
          if (last_take) begin
            state <= LELS_IDLE;
          end
        end
      endcase
    end
  end

  // access is latched whole so the processor side may change while cycles run
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      acc_write <= 1'b0;
      acc_addr <= 32'h0;
      acc_wdata <= 64'h0;
      wlog <= 2'h2;
      blog <= 2'h0;
      beats <= 4'h1;
      lane <= 2'h0;
    end else if (req_take) begin
      acc_write <= req_write;
      acc_addr <= req_addr;
      acc_wdata <= req_wdata;
      wlog <= next_wlog;
      blog <= next_blog;
      beats <= 4'h1 << next_cnt_log; // RULE2 RULE3 RULE4
      lane <= req_addr[1:0] & ((2'h1 << next_wlog) - 2'h1); // RULE1
    end
  end

  // lanes used by one cycle: 2**blog ones from the lane offset upward
  assign beat_mask = 4'((5'h1 << (3'h1 << blog)) - 5'h1) << lane; // RULE1 RULE3 RULE4 RULE6
  assign src_shift = 6'({issued[2:0], 3'h0} << wlog); // RULE3 RULE4
  assign beat_src = acc_wdata >> src_shift;
  assign dst_shift = 6'({acked[2:0], 3'h0} << wlog);

  assign beat_ch.valid = (state == LELS_ISSUE);
  assign issue_take = beat_ch.valid && beat_ch.ready;
  always_comb begin
    beat_ch.beat.write = acc_write;
    beat_ch.beat.strobe = beat_mask;
    // ascending cycle addresses, one device width apart
    beat_ch.beat.addr = acc_addr + (32'(issued) << wlog); // RULE2 RULE3 RULE4
    beat_ch.beat.data = beat_src[31:0] << {lane, 3'h0}; // RULE1 RULE2
  end

  // cycles handed to the buffer; also picks the data slice of the next one
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      issued <= 4'h0;
    end else if (req_take) begin
      issued <= 4'h0;
    end else if (issue_take) begin
      issued <= issued + 4'h1;
    end
  end

  // two entries let the sequencer run ahead while the bus stalls
  lels_pair_buf #(
    .WIDTH(`LELS_BEAT_W)
  ) u_buf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_side(beat_ch),
    .out_valid(bus_valid),
    .out_ready(bus_ready),
    .out_data(out_raw)
  );

  assign out_beat = lels_beat_t'(out_raw);
  assign bus_take = bus_valid && bus_ready;
  // the final acknowledge closes the access and frees the request side
  assign last_take = bus_take && (acked == beats - 4'h1);
  assign bus_write = out_beat.write;
  assign bus_addr = out_beat.addr;
  assign bus_wdata = out_beat.data;

  // one strobe vector qualifies each lane for all three memory styles
  assign write_lane0_strobe = bus_valid && out_beat.write && out_beat.strobe[0]; // RULE5
  assign write_lane1_strobe = bus_valid && out_beat.write && out_beat.strobe[1]; // RULE5
  assign write_lane2_strobe = bus_valid && out_beat.write && out_beat.strobe[2]; // RULE5
  assign write_lane3_strobe = bus_valid && out_beat.write && out_beat.strobe[3]; // RULE5
  assign column_lane0_strobe = bus_valid && out_beat.strobe[0]; // RULE5
  assign column_lane1_strobe = bus_valid && out_beat.strobe[1]; // RULE5
  assign column_lane2_strobe = bus_valid && out_beat.strobe[2]; // RULE5
  assign column_lane3_strobe = bus_valid && out_beat.strobe[3]; // RULE5
  assign sdram_lane0_mask = bus_valid && out_beat.strobe[0]; // RULE5
  assign sdram_lane1_mask = bus_valid && out_beat.strobe[1]; // RULE5
  assign sdram_lane2_mask = bus_valid && out_beat.strobe[2]; // RULE5
  assign sdram_lane3_mask = bus_valid && out_beat.strobe[3]; // RULE5

  // read lanes outside the strobe are dropped, never merged
  always_comb begin
    rd_lanes = bus_rdata >> {lane, 3'h0};
    rd_lanes = rd_lanes & (32'((33'h1 << {(3'h1 << blog), 3'h0}) - 33'h1)); // RULE6
    rd_piece = {32'h0, rd_lanes} << dst_shift; // RULE3 RULE4
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      acked <= 4'h0;
      rdata <= 64'h0;
    end else if (req_take) begin
      acked <= 4'h0;
      rdata <= 64'h0;
    end else if (bus_take) begin
      acked <= acked + 4'h1;
      rdata <= rdata | rd_piece;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 64'h0;
    end else begin
      // no back-pressure here: the processor side must catch the pulse
      rsp_valid <= last_take;
      if (last_take && !acc_write) begin
        rsp_rdata <= rdata | rd_piece;
      end
    end
  end
endmodule

// File: lels_lane_steer_checker.sv
// port checker for the lane steering block
`timescale 1ns/1ps
module lels_lane_steer_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [1:0] dev_width,
  input wire logic bus_valid,
  input wire logic bus_ready,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic write_lane0_strobe,
  input wire logic write_lane1_strobe,
  input wire logic write_lane2_strobe,
  input wire logic write_lane3_strobe,
  input wire logic column_lane0_strobe,
  input wire logic column_lane1_strobe,
  input wire logic column_lane2_strobe,
  input wire logic column_lane3_strobe,
  input wire logic sdram_lane0_mask,
  input wire logic sdram_lane1_mask,
  input wire logic sdram_lane2_mask,
  input wire logic sdram_lane3_mask
);
  wire [3:0] ws = {write_lane3_strobe, write_lane2_strobe, write_lane1_strobe,
    write_lane0_strobe};
  wire [3:0] cs = {column_lane3_strobe, column_lane2_strobe, column_lane1_strobe,
    column_lane0_strobe};
  wire [3:0] ms = {sdram_lane3_mask, sdram_lane2_mask, sdram_lane1_mask, sdram_lane0_mask};
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_mask_col: assert property (ms == cs)
    else $error("mask and column strobe differ");
  a_write_col: assert property (ws == (cs & {4{bus_write}}))
    else $error("write strobe wrong");
  a_idle_quiet: assert property (!bus_valid |-> cs == 4'h0)
    else $error("strobe outside a bus cycle");
  a_lane_byte: assert property (bus_valid && dev_width == 2'h0 |-> cs == 4'h1)
    else $error("8-bit device lane wrong");
  a_lane_half: assert property (bus_valid && dev_width == 2'h1 |->
    cs[3:2] == 2'h0 && cs[bus_addr[0]]) else $error("16-bit device lane wrong");
  a_lane_word: assert property (bus_valid && dev_width[1] |-> cs[bus_addr[1:0]])
    else $error("32-bit device lane wrong");
  a_stall_hold: assert property (bus_valid && !bus_ready |=>
    bus_valid && $stable(bus_addr) && $stable(cs)) else $error("cycle dropped in stall");
  c_stall: cover property (bus_valid && !bus_ready);
  c_last_byte: cover property (bus_valid && dev_width == 2'h0 && bus_addr[2:0] == 3'h7);
  c_wide_write: cover property (bus_valid && bus_write && cs == 4'hF);
endmodule
bind lels_lane_steer lels_lane_steer_checker u_chk (.*);

// File: lels_mem_model.sv
// external memory model with random wait states
`timescale 1ns/1ps
module lels_mem_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hold,
  input wire logic [1:0] dev_width,
  input wire logic bus_valid,
  output logic bus_ready,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  input wire logic [3:0] cs
);
  logic [7:0] mem [256];
  logic [31:0] junk = 32'hA5C30F96;
  int seed = 32'hB46725A2;
  wire [7:0] wa = bus_addr[7:0] & ~(dev_width == 2'h0 ? 8'h00 : dev_width == 2'h1 ? 8'h01 : 8'h03);
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  // unqualified lanes toggle so stale data never looks valid
  always_comb begin
    for (int j = 0; j < 4; j++) begin
      bus_rdata[8*j+:8] = cs[j] ? mem[8'(wa+j)] : junk[8*j+:8];
    end
  end
  always @(posedge clk_sys) begin
    junk <= ~junk;
    bus_ready <= nrst && !hold && (($random(seed) & 3) != 0);
    if (bus_valid && bus_ready && bus_write)
      for (int j = 0; j < 4; j++) if (cs[j]) mem[8'(wa+j)] <= bus_wdata[8*j+:8];
  end
endmodule

// File: tb_lels_lane_steer.sv
// self-checking bench for the lane steering block
`timescale 1ns/1ps
module tb_lels_lane_steer;
  logic clk_sys = 0, nrst = 0, req_valid = 0, req_write = 0, hold = 0;
  logic [1:0] dev_width = 0, req_size = 0;
  logic [31:0] req_addr = 0, base = 0;
  logic [63:0] req_wdata = 0;
  logic req_ready, rsp_valid, bus_valid, bus_ready, bus_write;
  logic [63:0] rsp_rdata;
  logic [31:0] bus_addr, bus_wdata, bus_rdata;
  logic write_lane0_strobe, write_lane1_strobe, write_lane2_strobe, write_lane3_strobe;
  logic column_lane0_strobe, column_lane1_strobe, column_lane2_strobe, column_lane3_strobe;
  logic sdram_lane0_mask, sdram_lane1_mask, sdram_lane2_mask, sdram_lane3_mask;
  logic [7:0] rm [256];
  int error_cnt = 0, tests_run = 0, k = 0, bw = 1, seed = 32'hB46725A2;
  lels_lane_steer dut (.*);
  lels_mem_model u_mem (.*, .cs({column_lane3_strobe, column_lane2_strobe,
    column_lane1_strobe, column_lane0_strobe}));
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic chk_bus(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_data(string nm, logic [63:0] e, logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task summarize;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wt(bit sel);
    for (int t = 0; t < 300; t++) begin
      @(negedge clk_sys);
      if ((sel ? rsp_valid : req_ready) === 1'b1) return;
    end
    error_cnt++;
    $display("BAD handshake exp 1 got 0");
    summarize();
  endtask
  always @(posedge clk_sys) if (nrst && bus_valid && bus_ready) begin
    chk_bus("bus_addr", base + k * bw, bus_addr);
    k++;
  end
  task automatic acc(logic w, logic [1:0] dw, logic [1:0] sz, logic [7:0] a0, logic [63:0] d);
    int nb;
    logic [7:0] a;
    logic [63:0] e, m;
    nb = 1 << sz;
    a = a0 & ~8'(nb - 1);
    @(posedge clk_sys);
    bw = dw == 2'h0 ? 1 : dw == 2'h1 ? 2 : 4;
    if (bw > nb) bw = nb;
    base = {24'h0, a};
    k = 0;
    {req_valid, req_write, req_size, dev_width} <= {1'b1, w, sz, dw};
    req_addr <= {24'h0, a};
    req_wdata <= d;
    wt(0);
    @(posedge clk_sys) req_valid <= 0;
    wt(1);
    e = 0;
    m = 0;
    for (int i = 0; i < nb; i++) begin
      e[8*i+:8] = rm[8'(a+i)];
      m[8*i+:8] = 8'hFF;
      if (w) rm[8'(a+i)] = d[8*i+:8];
    end
    if (!w) chk_data("rsp_rdata", e, rsp_rdata & m);
    chk_bus("beats", nb / bw, k);
  endtask
  initial begin
    for (int i = 0; i < 256; i++) rm[i] = i[7:0];
    repeat (20) @(posedge clk_sys);
    nrst <= 1;
    for (int dw = 0; dw < 4; dw++) for (int s = 0; s < 4; s++) begin
      acc(1, 2'(dw), 2'(s), 8'h10, {$random(seed), $random(seed)});
      acc(0, 2'(dw), 2'(s), 8'h10, 64'h0);
    end
    // long stall: buffer fills, request side must stay refused
    fork
      acc(1, 2'h0, 2'h3, 8'h20, {$random(seed), $random(seed)});
      begin
        repeat (3) @(posedge clk_sys);
        hold <= 1;
        repeat (20) @(negedge clk_sys);
        chk_bus("req_ready", 0, {31'h0, req_ready});
        @(posedge clk_sys) hold <= 0;
      end
    join
    acc(0, 2'h0, 2'h3, 8'h20, 64'h0);
    repeat (150) acc(1'($random(seed)), 2'($random(seed)), 2'($random(seed)),
      8'($random(seed)) & 8'h3F, {$random(seed), $random(seed)});
    summarize();
  end
endmodule
